/* uart_irq_modem_params.svh */
// register offsets, field positions, reset values and timing counts
`ifndef UART_IRQ_MODEM_PARAMS_SVH
`define UART_IRQ_MODEM_PARAMS_SVH
`define OFS_IDENT        8'h00
`define OFS_ENABLE       8'h04
`define OFS_MODEM_CTRL   8'h08
`define OFS_MODEM_STAT   8'h0c
`define OFS_SCRATCH      8'h10
`define OFS_FIFO_CTRL    8'h14
`define OFS_RX_READ      8'h18
`define OFS_TX_WRITE     8'h1c
`define OFS_LINK_STAT    8'h20
`define BIT_LOOPBACK     4
`define BIT_FIFO_ENABLE  0
`define RESET_BYTE       8'h00
`define CODE_LINE        3'h3
`define CODE_RXDATA      3'h2
`define CODE_TIMEOUT     3'h6
`define CODE_TXEMPTY     3'h1
`define CODE_MODEM       3'h0
`define TIMEOUT_CHARS    4
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

/* uart_irq_modem_pkg.sv */
// types shared by the interrupt and modem control block
package uart_irq_modem_pkg;
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_RESP
  } rd_state_e;
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_e;
endpackage

/* uart_irq_modem.sv */
// interrupt priority, identification, enable and modem control/status logic with axi4-lite registers
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "uart_irq_modem_params.svh"

module uart_irq_modem #(
  parameter int FIFO_DEPTH_W = 5  // level width, counts up to 16
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // receive side status from the receiver and its fifo
  input  wire logic        lineErr,
  input  wire logic        rxDataAvail,
  input  wire logic [FIFO_DEPTH_W-1:0] rxLevel,
  input  wire logic        rxCharDone,
  input  wire logic        rxCharTick,
  // transmit side status from the transmitter and its fifo
  input  wire logic        txFifoEmpty,
  input  wire logic [FIFO_DEPTH_W-1:0] txLevel,
  input  wire logic        txShiftOut,
  input  wire logic        txNearDone,
  // serial and modem pins, active low modem lines
  input  wire logic        serial_rx_pin,
  input  wire logic        ctsN,
  input  wire logic        dsrN,
  input  wire logic        riN,
  input  wire logic        dcdN,
  output logic             serial_tx_pin,
  output logic             dtrN,
  output logic             rtsN,
  output logic             aux1N,
  output logic             aux2N,
  // to the core
  output logic             rxSerialIn,
  output logic             rxFifoRead,
  output logic             txFifoWrite,
  output logic [7:0]       txByte,
  output logic             fifoFlush,
  output logic [1:0]       rxTrigSel,
  output logic             irq_out
);

  // the entire state in one packed struct
  typedef struct packed {
    uart_irq_modem_pkg::rd_state_e rdState;
    uart_irq_modem_pkg::wr_state_e wrState;
    logic        awHave;     // write address caught
    logic        wHave;      // write data caught
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [1:0]  bResp;
    logic [7:0]  interrupt_enable_mask;
    logic [7:0]  modem_line_control;
    logic [7:0]  scratch_byte;
    logic        fifo_enable_bit;
    logic [1:0]  trigSel;
    logic [3:0]  changeBits;  // cts, dsr, ring, dcd change flags
    logic [3:0]  syncA;       // first synchroniser stage
    logic [3:0]  syncB;       // second synchroniser stage
    logic [3:0]  prevLine;    // last seen modem line level (true sense)
    logic        rxSyncA;
    logic        rxSyncB;
    logic [3:0]  identHeld;   // frozen identification nibble
    logic        identBusy;   // read of identification under way
    logic [3:0]  idleChars;   // character times since rx activity
    logic        timeoutPend;
    logic        txEmptyPend; // tx empty class latched pending
    logic        twoHeld;     // fifo held two bytes since empty rose
    logic        emptyArmed;  // first empty after mode change is immediate
    logic        emptyPrev;
    logic        txDelayed;   // delayed empty indication
    logic        serialTx;
    logic [3:0]  modemOutN;
    logic        rxIn;
    logic        rxPop;
    logic        txPush;
    logic [7:0]  txData;
    logic        flush;
    logic        irq;
  } state_s;

  state_s cur;   // registered state
  state_s nxt;   // next state

  // derived terms
  logic        loop;          // loopback mode
  logic [3:0]  lineNow;       // modem lines in true sense: cts, dsr, ri, dcd
  logic [FIFO_DEPTH_W-1:0] trigLevel;
  logic        lineP;
  logic        rxP;
  logic        txP;
  logic        modemP;
  logic [3:0]  identNow;
  logic        rdIdent;
  logic        rdModem;
  logic        doWrite;
  logic [7:0]  wByte;

  // trigger level decode, used for the rx threshold
  function automatic logic [FIFO_DEPTH_W-1:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'b00:   trig_level = FIFO_DEPTH_W'(1);
      2'b01:   trig_level = FIFO_DEPTH_W'(4);
      2'b10:   trig_level = FIFO_DEPTH_W'(8);
      2'b11:   trig_level = FIFO_DEPTH_W'(14);
    endcase
  endfunction

  // priority encode of pending classes into the identification nibble
  function automatic logic [3:0] ident_code(input logic ln, input logic rx, input logic to,
                                             input logic tx, input logic md);
    if (ln) begin
      ident_code = {`CODE_LINE, 1'b0};
    end else if (rx || to) begin
      ident_code = {(to ? `CODE_TIMEOUT : `CODE_RXDATA), 1'b0};
    end else if (tx) begin
      ident_code = {`CODE_TXEMPTY, 1'b0};
    end else if (md) begin
      ident_code = {`CODE_MODEM, 1'b0};
    end else begin
      ident_code = 4'h1;
    end
  endfunction

  // next-state logic
  always_comb begin
    nxt = cur;
    loop = cur.modem_line_control[`BIT_LOOPBACK];
    trigLevel = trig_level(cur.trigSel);
    // loopback feeds control bits back as the modem inputs
    lineNow = loop ? {cur.modem_line_control[3], cur.modem_line_control[2],
                      cur.modem_line_control[0], cur.modem_line_control[1]}
                   : ~cur.syncB;
    // class pending terms gated by enables
    lineP  = cur.interrupt_enable_mask[2] && lineErr;
    rxP    = cur.interrupt_enable_mask[0] &&
             (cur.fifo_enable_bit ? (rxLevel >= trigLevel) : rxDataAvail);
    txP    = cur.interrupt_enable_mask[1] && cur.txEmptyPend;
    modemP = cur.interrupt_enable_mask[3] && (cur.changeBits != 4'h0);
    identNow = ident_code(lineP, rxP, cur.interrupt_enable_mask[0] && cur.timeoutPend, txP, modemP);
    // single-cycle strobes
    nxt.rxPop = 1'b0;
    nxt.txPush = 1'b0;
    nxt.flush = 1'b0;
    rdIdent = 1'b0;
    rdModem = 1'b0;
    doWrite = 1'b0;
    wByte = cur.wData[7:0];
    // pin synchronisers
    nxt.syncA = {dcdN, riN, dsrN, ctsN};
    nxt.syncB = cur.syncA;
    nxt.rxSyncA = serial_rx_pin;
    nxt.rxSyncB = cur.rxSyncA;
    nxt.rxIn = loop ? txShiftOut : cur.rxSyncB;
    nxt.serialTx = loop ? 1'b1 : txShiftOut;
    nxt.modemOutN = loop ? 4'hf : ~cur.modem_line_control[3:0];
    nxt.prevLine = lineNow;
    // read channel
    unique case (cur.rdState)
      uart_irq_modem_pkg::RD_IDLE: begin
        if (s_axi_arvalid) begin
          nxt.rResp = `RESP_OKAY;
          nxt.rdState = uart_irq_modem_pkg::RD_RESP;
          unique case (s_axi_araddr)
            `OFS_IDENT: begin
              rdIdent = 1'b1;
              nxt.identBusy = 1'b1;
              nxt.identHeld = identNow;   // frozen for this access
              nxt.rData = {24'h0, {2{cur.fifo_enable_bit}}, 2'b00, identNow};
            end
            `OFS_ENABLE:     nxt.rData = {24'h0, 4'h0, cur.interrupt_enable_mask[3:0]};
            `OFS_MODEM_CTRL: nxt.rData = {24'h0, 3'h0, cur.modem_line_control[4:0]};
            `OFS_MODEM_STAT: begin
              rdModem = 1'b1;
              nxt.rData = {24'h0, lineNow[3], lineNow[2], lineNow[1], lineNow[0],
                           cur.changeBits[3], cur.changeBits[2], cur.changeBits[1],
                           cur.changeBits[0]};
            end
            `OFS_SCRATCH:    nxt.rData = {24'h0, cur.scratch_byte};
            `OFS_FIFO_CTRL:  nxt.rData = {24'h0, cur.trigSel, 5'h0, cur.fifo_enable_bit};
            `OFS_RX_READ: begin
              nxt.rxPop = 1'b1;
              nxt.rData = 32'h0;
            end
            `OFS_LINK_STAT:  nxt.rData = {28'h0, cur.txDelayed, txFifoEmpty, lineErr, rxDataAvail};
            default: begin
              nxt.rData = 32'h0;
              nxt.rResp = `RESP_SLVERR;
            end
          endcase
        end
      end
      uart_irq_modem_pkg::RD_RESP: begin
        if (s_axi_rready) begin
          nxt.rdState = uart_irq_modem_pkg::RD_IDLE;
          nxt.identBusy = 1'b0;   // access done, indication may move again
        end
      end
    endcase
    // write channel, address and data in either order
    if (cur.wrState == uart_irq_modem_pkg::WR_IDLE) begin
      if (s_axi_awvalid && !cur.awHave) begin
        nxt.awHave = 1'b1;
        nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !cur.wHave) begin
        nxt.wHave = 1'b1;
        nxt.wData = s_axi_wdata;
        nxt.wStrb = s_axi_wstrb;
      end
      if (cur.awHave && cur.wHave) begin
        doWrite = cur.wStrb[0];
        nxt.bResp = `RESP_OKAY;
        nxt.wrState = uart_irq_modem_pkg::WR_RESP;
        nxt.awHave = 1'b0;
        nxt.wHave = 1'b0;
        if (doWrite) begin
          unique case (cur.awAddr)
            `OFS_ENABLE:     nxt.interrupt_enable_mask = {4'h0, wByte[3:0]};
            `OFS_MODEM_CTRL: nxt.modem_line_control = {3'h0, wByte[4:0]};
            `OFS_SCRATCH:    nxt.scratch_byte = wByte;
            `OFS_FIFO_CTRL: begin
              nxt.fifo_enable_bit = wByte[`BIT_FIFO_ENABLE];
              if (wByte[`BIT_FIFO_ENABLE]) begin
                nxt.trigSel = wByte[7:6];
              end
              if (wByte[`BIT_FIFO_ENABLE] != cur.fifo_enable_bit) begin
                nxt.flush = 1'b1;                  // mode change empties both fifos
                nxt.emptyArmed = 1'b1;
              end
            end
            `OFS_TX_WRITE: begin
              nxt.txPush = 1'b1;
              nxt.txData = wByte;
            end
            `OFS_IDENT, `OFS_MODEM_STAT, `OFS_RX_READ, `OFS_LINK_STAT: ;
            default:         nxt.bResp = `RESP_SLVERR;
          endcase
        end else if (!(cur.awAddr inside {`OFS_IDENT, `OFS_ENABLE, `OFS_MODEM_CTRL, `OFS_MODEM_STAT,
                                          `OFS_SCRATCH, `OFS_FIFO_CTRL, `OFS_RX_READ, `OFS_TX_WRITE,
                                          `OFS_LINK_STAT})) begin
          nxt.bResp = `RESP_SLVERR;
        end
      end
    end else if (s_axi_bready) begin
      nxt.wrState = uart_irq_modem_pkg::WR_IDLE;
    end
    // modem change flags; a new change wins over the clearing read
    if (rdModem) begin
      nxt.changeBits = 4'h0;
    end
    nxt.changeBits[0] = nxt.changeBits[0] | (lineNow[0] ^ cur.prevLine[0]);
    nxt.changeBits[1] = nxt.changeBits[1] | (lineNow[1] ^ cur.prevLine[1]);
    nxt.changeBits[2] = nxt.changeBits[2] | (cur.prevLine[2] & ~lineNow[2]); // ring pin low-to-high
    nxt.changeBits[3] = nxt.changeBits[3] | (lineNow[3] ^ cur.prevLine[3]);
    // receive timeout counter on the character tick
    if (!cur.fifo_enable_bit || rxLevel == '0 || rxCharDone || cur.rxPop) begin
      nxt.idleChars = 4'h0;
      nxt.timeoutPend = 1'b0;
    end else if (rxCharTick && cur.idleChars < 4'(`TIMEOUT_CHARS)) begin
      nxt.idleChars = cur.idleChars + 4'h1;
    end
    if (cur.fifo_enable_bit && rxLevel != '0 && !rxCharDone && !cur.rxPop &&
        cur.idleChars == 4'(`TIMEOUT_CHARS)) begin
      nxt.timeoutPend = 1'b1;
    end
    // transmit empty indication with optional one-character delay
    nxt.emptyPrev = txFifoEmpty;
    if (!txFifoEmpty && txLevel >= FIFO_DEPTH_W'(2)) begin
      nxt.twoHeld = 1'b1;
    end
    if (txFifoEmpty && !cur.emptyPrev) begin
      nxt.twoHeld = 1'b0;
    end
    if (!txFifoEmpty) begin
      nxt.txDelayed = 1'b0;
    end else if (!cur.fifo_enable_bit || cur.twoHeld || cur.emptyArmed || txNearDone) begin
      nxt.txDelayed = 1'b1;
      nxt.emptyArmed = 1'b0;
    end
    // tx empty class: rises with indication, cleared by ident read or write
    if ((rdIdent && identNow == {`CODE_TXEMPTY, 1'b0}) || nxt.txPush) begin
      nxt.txEmptyPend = 1'b0;
    end
    if (cur.txDelayed == 1'b0 && nxt.txDelayed) begin
      nxt.txEmptyPend = 1'b1;      // rise beats a clear in the same cycle
    end
    nxt.irq = (cur.identBusy ? cur.identHeld[0] : identNow[0]) == 1'b0;
  end

  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.syncA <= 4'hf;
      cur.syncB <= 4'hf;
      cur.prevLine <= 4'h0;
      cur.rxSyncA <= 1'b1;
      cur.rxSyncB <= 1'b1;
      cur.rxIn <= 1'b1;
      cur.serialTx <= 1'b1;
      cur.modemOutN <= 4'hf;
      cur.identHeld <= 4'h1;
      cur.emptyArmed <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  // outputs straight from state
  assign s_axi_awready = (cur.wrState == uart_irq_modem_pkg::WR_IDLE) && !cur.awHave;
  assign s_axi_wready  = (cur.wrState == uart_irq_modem_pkg::WR_IDLE) && !cur.wHave;
  assign s_axi_bvalid  = (cur.wrState == uart_irq_modem_pkg::WR_RESP);
  assign s_axi_bresp   = cur.bResp;
  assign s_axi_arready = (cur.rdState == uart_irq_modem_pkg::RD_IDLE);
  assign s_axi_rvalid  = (cur.rdState == uart_irq_modem_pkg::RD_RESP);
  assign s_axi_rdata   = cur.rData;
  assign s_axi_rresp   = cur.rResp;
  assign serial_tx_pin = cur.serialTx;
  assign dtrN          = cur.modemOutN[0];
  assign rtsN          = cur.modemOutN[1];
  assign aux1N         = cur.modemOutN[2];
  assign aux2N         = cur.modemOutN[3];
  assign rxSerialIn    = cur.rxIn;
  assign rxFifoRead    = cur.rxPop;
  assign txFifoWrite   = cur.txPush;
  assign txByte        = cur.txData;
  assign fifoFlush     = cur.flush;
  assign rxTrigSel     = cur.trigSel;
  assign irq_out       = cur.irq;

endmodule

/* uart_irq_modem_props.sv */
// concurrent checks on the ports of the interrupt and modem control block
`timescale 1ns/100ps
`include "uart_irq_modem_params.svh"
module uart_irq_modem_props (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // serial and modem side
  input wire logic        txShiftOut,
  input wire logic        serial_tx_pin,
  input wire logic        dtrN,
  input wire logic        rtsN,
  input wire logic        aux1N,
  input wire logic        aux2N,
  input wire logic        rxSerialIn,
  input wire logic        irq_out
);
  logic [7:0] awQ, wQ, arQ, mcrM; // captured bus fields and shadow of modem control
  logic [2:0] age;                // cycles since the shadow last changed, saturating
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // shadow the modem control byte from completed writes; pins lag it, so age gates the checks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {awQ, wQ, arQ, mcrM, age} <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) awQ <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wQ <= s_axi_wdata[7:0];
      if (s_axi_arvalid && s_axi_arready) arQ <= s_axi_araddr;
      if (s_axi_bvalid && s_axi_bready && awQ == `OFS_MODEM_CTRL) begin
        mcrM <= wQ;
        age  <= 3'h0;
      end else if (age != 3'h7) begin
        age <= age + 3'h1;
      end
    end
  end
  dtr_pin_a: assert property (age > 3'h2 |-> dtrN == (mcrM[4] | ~mcrM[0])) else $error("dtr pin wrong");
  rts_pin_a: assert property (age > 3'h2 |-> rtsN == (mcrM[4] | ~mcrM[1])) else $error("rts pin wrong");
  aux_pins_a: assert property (age > 3'h2 |-> {aux2N, aux1N} == ({2{mcrM[4]}} | ~mcrM[3:2]))
    else $error("aux pins wrong");
  loop_mark_a: assert property (age > 3'h2 && mcrM[4] |-> serial_tx_pin) else $error("tx not marking");
  loop_feed_a: assert property ((mcrM[4] && age > 3'h2 && txShiftOut)[*4] |-> rxSerialIn)
    else $error("loopback feed lost");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > `OFS_LINK_STAT
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  ident_bits_a: assert property (s_axi_rvalid && arQ == `OFS_IDENT |-> s_axi_rdata[5:4] == 2'b00
    && (!s_axi_rdata[3] || s_axi_rdata[2])) else $error("ident fixed bits wrong");
  irq_match_a: assert property (s_axi_rvalid && arQ == `OFS_IDENT |-> irq_out == !s_axi_rdata[0])
    else $error("irq disagrees with ident");
  enable_zero_a: assert property (s_axi_rvalid && arQ == `OFS_ENABLE |-> s_axi_rdata[7:4] == 4'h0)
    else $error("enable high bits set");
  ctrl_zero_a: assert property (s_axi_rvalid && arQ == `OFS_MODEM_CTRL |-> s_axi_rdata[7:5] == 3'h0)
    else $error("control high bits set");
  cover property (age > 3'h2 && mcrM[4]);
  cover property ($rose(irq_out));
  cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule
bind uart_irq_modem uart_irq_modem_props chk (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txShiftOut, .serial_tx_pin,
  .dtrN, .rtsN, .aux1N, .aux2N, .rxSerialIn, .irq_out);

/* uart_irq_modem_partner.sv */
// modem at the far end of the handshake lines, with a settling lag
`timescale 1ns/100ps
module uart_irq_modem_partner #(
  parameter int LAG = 2  // cycles before a requested line change shows on the pins
) (
  // clock and requested asserted lines {dcd, ri, dsr, cts}
  input  wire logic       sys_clk,
  input  wire logic [3:0] lineReq,
  // pins, low active modem lines
  output logic            ctsN,
  output logic            dsrN,
  output logic            riN,
  output logic            dcdN,
  output logic            serial_rx_pin
);
  logic [4*LAG-1:0] sh = '0;  // delay line, so the block sees a slow modem
  // shift requests through the lag
  always @(posedge sys_clk) begin
    sh <= {sh[4*LAG-5:0], lineReq};
  end
  assign {dcdN, riN, dsrN, ctsN} = ~sh[4*LAG-1 -: 4];
  assign serial_rx_pin = 1'b1;  // idle line sits at marking
endmodule

/* uart_irq_modem_bench.sv */
// self-checking bench for the interrupt and modem control block
`timescale 1ns/100ps
`include "uart_irq_modem_params.svh"
module uart_irq_modem_bench;
  logic        sys_clk = 1'b0, rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h1;  // only lane 0 carries data
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, rxTrigSel;
  wire  [31:0] s_axi_rdata;
  logic        lineErr = 0, rxDataAvail = 0, rxCharDone = 0, rxCharTick = 0;
  logic        txFifoEmpty = 0, txShiftOut = 1, txNearDone = 0;
  logic [4:0]  rxLevel = 5'h0, txLevel = 5'h0;
  logic [3:0]  lineReq = 4'h0;  // lines the modem asserts
  wire         serial_rx_pin, ctsN, dsrN, riN, dcdN, serial_tx_pin, dtrN, rtsN, aux1N, aux2N;
  wire         rxSerialIn, rxFifoRead, txFifoWrite, fifoFlush, irq_out;
  wire  [7:0]  txByte;
  logic [41:0] expQ[$];  // {mask, resp, data} noted by the read driver
  logic [41:0] ev;
  int          bad_count = 0, n_checks = 0, v;
  logic [7:0]  r;
  uart_irq_modem dut (.*);
  uart_irq_modem_partner #(.LAG(2)) modem (.sys_clk(sys_clk), .lineReq(lineReq), .ctsN(ctsN), .dsrN(dsrN),
    .riN(riN), .dcdN(dcdN), .serial_rx_pin(serial_rx_pin));
  always #2.5 sys_clk = ~sys_clk;
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // read answers are compared against the oldest note, masked to the bits that matter
  always @(posedge sys_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      ev = expQ.pop_front();
      check("rdata", {s_axi_rresp, s_axi_rdata} & {26'h3ffffff, ev[41:34]}, ev[33:0] & {26'h3ffffff, ev[41:34]});
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) begin
      bad_count++;
      end_of_test();
    end
  endtask
  // read: notes the expected word, releases the request when taken, then waits for the answer
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    int n;
    expQ.push_back({m, (a > `OFS_LINK_STAT) ? `RESP_SLVERR : `RESP_OKAY, 24'h0, e});
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) begin
      bad_count++;
      end_of_test();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk) rxCharTick <= 1'b1;
      @(posedge sys_clk) rxCharTick <= 1'b0;
    end
  endtask
  initial begin
    r = 8'($urandom(32'h26f1));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    // registers after reset, scratch, unmapped
    rd(`OFS_MODEM_STAT, 8'h00, 8'hf0);
    rd(`OFS_IDENT, 8'h01);
    rd(`OFS_ENABLE, 8'h00);
    r = 8'($urandom);
    wr(`OFS_SCRATCH, r);
    rd(`OFS_SCRATCH, r);
    rd(8'h24, 8'h00);
    wr(`OFS_ENABLE, 8'hff);
    rd(`OFS_ENABLE, 8'h0f);
    rd(`OFS_IDENT, 8'h01);
    $display("test registers done");
    // every control nibble reaches the pins inverted
    for (v = 0; v < 16; v++) begin
      wr(`OFS_MODEM_CTRL, 8'(v));
      idle(3);
      check("pins", {30'h0, aux2N, aux1N, rtsN, dtrN}, {30'h0, ~v[3:0]});
      rd(`OFS_MODEM_CTRL, 8'(v));
    end
    wr(`OFS_MODEM_CTRL, 8'hef);
    rd(`OFS_MODEM_CTRL, 8'h0f);
    $display("test control pins done");
    // change bits with the class disabled, then enabled
    wr(`OFS_ENABLE, 8'h00);
    lineReq <= 4'b1000;
    idle(8);
    check("irq", {33'h0, irq_out}, 34'h0);
    rd(`OFS_IDENT, 8'h01);
    rd(`OFS_MODEM_STAT, 8'h88);
    wr(`OFS_ENABLE, 8'h08);
    lineReq <= 4'b1001;
    idle(8);
    check("irq", {33'h0, irq_out}, 34'h1);
    rd(`OFS_IDENT, 8'h00);
    rd(`OFS_MODEM_STAT, 8'h91);
    rd(`OFS_IDENT, 8'h01);
    lineReq <= 4'b1101;
    idle(8);
    rd(`OFS_MODEM_STAT, 8'hd0);
    lineReq <= 4'b1001;
    idle(8);
    rd(`OFS_MODEM_STAT, 8'h94);
    $display("test modem status done");
    // loopback: pins parked, status from control bits, modem noise ignored
    wr(`OFS_MODEM_CTRL, 8'h16);
    lineReq <= 4'($urandom);
    idle(8);
    check("loop pins", {29'h0, serial_tx_pin, aux2N, aux1N, rtsN, dtrN}, 34'h1f);
    txShiftOut <= 1'b0;
    idle(6);
    check("loop rx", {33'h0, rxSerialIn}, 34'h0);
    txShiftOut <= 1'b1;
    rd(`OFS_MODEM_STAT, 8'h50, 8'hf0);
    wr(`OFS_MODEM_CTRL, 8'h17);
    idle(4);
    check("irq", {33'h0, irq_out}, 34'h1);
    rd(`OFS_MODEM_STAT, 8'h72);
    wr(`OFS_MODEM_CTRL, 8'h00);
    lineReq <= 4'h0;
    idle(8);
    rd(`OFS_MODEM_STAT, 8'h00, 8'h00);
    $display("test loopback done");
    // priority of line status over received data, and masking
    wr(`OFS_ENABLE, 8'h0f);
    lineErr <= 1'b1;
    rxDataAvail <= 1'b1;
    idle(3);
    rd(`OFS_IDENT, 8'h06);
    wr(`OFS_ENABLE, 8'h0b);
    rd(`OFS_IDENT, 8'h04);
    wr(`OFS_ENABLE, 8'h0f);
    lineErr <= 1'b0;
    idle(3);
    rd(`OFS_IDENT, 8'h04);
    rxDataAvail <= 1'b0;
    idle(3);
    rd(`OFS_IDENT, 8'h01);
    $display("test priority done");
    // fifo mode: trigger level, character timeout, transmit empty
    wr(`OFS_FIFO_CTRL, 8'hc1);
    check("trig sel", {32'h0, rxTrigSel}, 34'h3);
    idle(3);
    rd(`OFS_IDENT, 8'hc1);
    rxLevel <= 5'd14;
    rxDataAvail <= 1'b1;
    idle(3);
    rd(`OFS_IDENT, 8'hc4);
    rd(`OFS_LINK_STAT, 8'h01);
    rxLevel <= 5'(1 + $urandom % 13);
    @(posedge sys_clk) rxCharDone <= 1'b1;
    @(posedge sys_clk) rxCharDone <= 1'b0;
    tick(3);
    rd(`OFS_IDENT, 8'hc1);
    tick(2);
    rd(`OFS_IDENT, 8'hcc);
    rd(`OFS_RX_READ, 8'h00, 8'h00);
    rxLevel <= 5'd0;
    rxDataAvail <= 1'b0;
    idle(3);
    rd(`OFS_IDENT, 8'hc1);
    txFifoEmpty <= 1'b1;
    wr(`OFS_ENABLE, 8'h02);
    idle(3);
    rd(`OFS_IDENT, 8'hc2);
    rd(`OFS_IDENT, 8'hc1);
    // a lone byte since the last empty holds the next indication back
    txFifoEmpty <= 1'b0;
    idle(2);
    txFifoEmpty <= 1'b1;
    idle(4);
    rd(`OFS_IDENT, 8'hc1);
    txNearDone <= 1'b1;
    idle(3);
    check("irq", {33'h0, irq_out}, 34'h1);
    r = 8'($urandom);
    wr(`OFS_TX_WRITE, r);
    check("tx byte", {26'h0, txByte}, {26'h0, r});
    rd(`OFS_IDENT, 8'hc1);
    txFifoEmpty <= 1'b0;
    wr(`OFS_FIFO_CTRL, 8'h00);
    idle(3);
    rd(`OFS_IDENT, 8'h01);
    $display("test fifo mode done");
    idle(4);
    end_of_test();
  end
endmodule
